/* File: logic/rhs_pkg.sv */
// Package with offsets, bit positions and reset values of the root hub global status block.
package rhs_pkg;
    localparam logic [7:0] RHS_STATUS_OFFSET = 8'h50;
    localparam int RHS_BIT_CLR_WAKE = 31;
    localparam int RHS_BIT_OC_CHANGE = 17;
    localparam int RHS_BIT_SET_POWER = 16;
    localparam int RHS_BIT_SET_WAKE = 15;
    localparam int RHS_BIT_OC_FLAG = 1;
    localparam int RHS_BIT_CLR_POWER = 0;
    localparam logic [31:0] RHS_STATUS_RESET = 32'h0000_0000;
    typedef enum logic [1:0] {
        RHS_ACTIVE = 2'b01,
        RHS_SUSPENDED = 2'b10
    } rhs_hub_state_t;
endpackage

/* File: logic/rhs_cmd_if.sv */
// Interface carrying decoded write commands from the register bank to the power logic.
`timescale 1ns/1ns
interface rhs_cmd_if;
    logic set_all;
    logic clr_all;
    modport src (output set_all, output clr_all);
    modport dst (input set_all, input clr_all);
endinterface

/* File: logic/rhs_port_power.sv */
// Per-port power state switched by global commands under mode and mask control.
`timescale 1ns/1ns
module rhs_port_power
#(
    parameter int NUM_PORTS = 4
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    rhs_cmd_if.dst cmd,
    input wire logic per_port_mode,
    input wire logic [NUM_PORTS-1:0] port_power_mask,
    input wire logic [NUM_PORTS-1:0] port_set_power,
    input wire logic [NUM_PORTS-1:0] port_clr_power,
    output logic [NUM_PORTS-1:0] port_power_q
);
    import rhs_pkg::*;
    logic [NUM_PORTS-1:0] port_power_d;
    logic [NUM_PORTS-1:0] global_sel;

    always_comb
    begin
        // Mask only matters in per-port mode; in global mode every port follows.
        global_sel = per_port_mode ? ~port_power_mask : {NUM_PORTS{1'b1}};
        port_power_d = port_power_q;
        port_power_d = port_power_d | (port_set_power & port_power_mask & {NUM_PORTS{per_port_mode}});
        port_power_d = port_power_d & ~(port_clr_power & port_power_mask & {NUM_PORTS{per_port_mode}});
        if (cmd.set_all)
        begin
            port_power_d = port_power_d | global_sel;
        end
        if (cmd.clr_all)
        begin
            port_power_d = port_power_d & ~global_sel;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            port_power_q <= '0;
        end
        else
        begin
            port_power_q <= port_power_d;
        end
    end
endmodule

/* File: logic/rhs_global_status.sv */
// Root hub global status and control register with wake and resume tracking.
`timescale 1ns/1ns
module rhs_global_status
#(
    parameter int NUM_PORTS = 4,
    parameter bit PER_PORT_OC = 1'b0
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata_q,
    input wire logic per_port_mode,
    input wire logic [NUM_PORTS-1:0] port_power_mask,
    input wire logic [NUM_PORTS-1:0] port_set_power,
    input wire logic [NUM_PORTS-1:0] port_clr_power,
    input wire logic overcurrent_in,
    input wire logic [NUM_PORTS-1:0] connect_change_flag,
    input wire logic suspend_req,
    output logic [NUM_PORTS-1:0] port_power_q,
    output logic remote_wake_enable_q,
    output logic resume_detected_q,
    output logic resuming_state_q
);
    import rhs_pkg::*;

    rhs_cmd_if cmd_bus();
    logic hit;
    // Decoded access strobes and the command bits of a write to this register.
    logic wr_hit;
    logic rd_hit;
    logic set_wake_cmd;
    logic clr_wake_cmd;
    logic clr_occ_cmd;

    logic wake_d;
    logic oc_d;
    logic oc_q;
    logic occ_d;
    logic occ_q;
    logic resume_d;
    logic resuming_d;
    logic [31:0] rdata_d;
    logic wake_event;

    rhs_hub_state_t state_d;
    rhs_hub_state_t state_q;

    assign hit = reg_addr == RHS_STATUS_OFFSET;
    assign wr_hit = reg_wr && hit;
    assign rd_hit = reg_rd && hit;
    assign set_wake_cmd = wr_hit && reg_wdata[RHS_BIT_SET_WAKE];
    assign clr_wake_cmd = wr_hit && reg_wdata[RHS_BIT_CLR_WAKE];
    assign clr_occ_cmd = wr_hit && reg_wdata[RHS_BIT_OC_CHANGE];
    // Only the global commands cross to the power module; per-port pulses go there directly.
    assign cmd_bus.set_all = wr_hit && reg_wdata[RHS_BIT_SET_POWER];
    assign cmd_bus.clr_all = wr_hit && reg_wdata[RHS_BIT_CLR_POWER];

    rhs_port_power #(.NUM_PORTS(NUM_PORTS)) u_power
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .cmd(cmd_bus.dst),
        .per_port_mode(per_port_mode),
        .port_power_mask(port_power_mask),
        .port_set_power(port_set_power),
        .port_clr_power(port_clr_power),
        .port_power_q(port_power_q)
    );

    always_comb
    begin
        wake_d = remote_wake_enable_q;
        if (set_wake_cmd)
        begin
            wake_d = 1'b1;
        end
        // Clear comes last so a write with both command bits leaves wake-up off.
        if (clr_wake_cmd)
        begin
            wake_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            remote_wake_enable_q <= 1'b0;
        end
        else
        begin
            remote_wake_enable_q <= wake_d;
        end
    end

    always_comb
    begin
        // The flag is hardware-owned; bus writes never reach it.
        oc_d = PER_PORT_OC ? 1'b0 : overcurrent_in;
        occ_d = occ_q;
        if (clr_occ_cmd)
        begin
            occ_d = 1'b0;
        end
        // Set is placed after the clear so a coincident change is not lost.
        if (oc_d != oc_q)
        begin
            occ_d = 1'b1;
        end
    end

    // A condition already present when reset ends counts as a change and sets the flag.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            oc_q <= 1'b0;
            occ_q <= 1'b0;
        end
        else
        begin
            oc_q <= oc_d;
            occ_q <= occ_d;
        end
    end

    // Only a suspended hub can be woken, and only while wake-up is enabled.
    always_comb
    begin
        wake_event = remote_wake_enable_q && (|connect_change_flag);
        state_d = state_q;
        resume_d = 1'b0;
        resuming_d = 1'b0;
        unique case (state_q)
            RHS_ACTIVE:
            begin
                if (suspend_req)
                begin
                    state_d = RHS_SUSPENDED;
                end
            end
            RHS_SUSPENDED:
            begin
                if (wake_event)
                begin
                    state_d = RHS_ACTIVE;
                    resume_d = 1'b1;
                    resuming_d = 1'b1;
                end
            end
            default:
            begin
                // An illegal code falls back to active rather than locking up.
                state_d = RHS_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state_q <= RHS_ACTIVE;
            resume_detected_q <= 1'b0;
            resuming_state_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            resume_detected_q <= resume_d;
            resuming_state_q <= resuming_d;
        end
    end

    always_comb
    begin
        // Command bits 31, 16 and 0 read back as zero.
        rdata_d = RHS_STATUS_RESET;
        if (rd_hit)
        begin
            rdata_d[RHS_BIT_OC_CHANGE] = occ_q;
            rdata_d[RHS_BIT_SET_WAKE] = remote_wake_enable_q;
            rdata_d[RHS_BIT_OC_FLAG] = oc_q;
        end
    end

    // Registering the read data costs a cycle of latency but keeps the port glitch free.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            reg_rdata_q <= RHS_STATUS_RESET;
        end
        else
        begin
            reg_rdata_q <= rdata_d;
        end
    end
endmodule

/* File: test/rhs_global_status_properties.sv */
// Concurrent checks on the ports of the root hub global status block.
`timescale 1ns/1ns
module rhs_status_chk
    import rhs_pkg::*;
#(
    parameter int NUM_PORTS = 4
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata_q,
    input wire logic per_port_mode,
    input wire logic [NUM_PORTS-1:0] port_power_mask,
    input wire logic [NUM_PORTS-1:0] port_set_power,
    input wire logic [NUM_PORTS-1:0] port_clr_power,
    input wire logic overcurrent_in,
    input wire logic [NUM_PORTS-1:0] connect_change_flag,
    input wire logic [NUM_PORTS-1:0] port_power_q,
    input wire logic remote_wake_enable_q,
    input wire logic resume_detected_q,
    input wire logic resuming_state_q
);
    wire w = reg_wr && reg_addr == RHS_STATUS_OFFSET;
    wire rd = reg_rd && reg_addr == RHS_STATUS_OFFSET;
    wire any_cc = |connect_change_flag;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    property p_wset; w && reg_wdata[15] && !reg_wdata[31] |=> remote_wake_enable_q; endproperty
    a_wset: assert property (p_wset) else $error("wake set");
    property p_wclr; w && reg_wdata[31] |=> !remote_wake_enable_q; endproperty
    a_wclr: assert property (p_wclr) else $error("wake clear");
    property p_rd0; rd |=> !reg_rdata_q[16] && !reg_rdata_q[0]; endproperty
    a_rd0: assert property (p_rd0) else $error("bit 16 or 0 set");
    property p_oc; rd && $stable(overcurrent_in) |=> reg_rdata_q[1] == $past(overcurrent_in); endproperty
    a_oc: assert property (p_oc) else $error("overcurrent bit");
    // The two idle slots keep a clearing write from masking the flag.
    property p_occ; $changed(overcurrent_in) ##1 !w ##1 rd && !w |=> reg_rdata_q[17]; endproperty
    a_occ: assert property (p_occ) else $error("change flag");
    property p_pset; w && reg_wdata[16] && !reg_wdata[0] && !per_port_mode |=> port_power_q == '1; endproperty
    a_pset: assert property (p_pset) else $error("global power");
    property p_pmask; w && per_port_mode && !port_set_power && !port_clr_power |=>
        (port_power_q & $past(port_power_mask)) ==
        ($past(port_power_q) & $past(port_power_mask)); endproperty
    a_pmask: assert property (p_pmask) else $error("masked port");
    property p_res; resume_detected_q |-> resuming_state_q && $past(remote_wake_enable_q)
        && $past(any_cc); endproperty
    a_res: assert property (p_res) else $error("resume");
    c_res: cover property (resume_detected_q);
    c_pp: cover property (w && per_port_mode);
    c_occ: cover property (reg_rdata_q[17]);
endmodule
bind rhs_global_status rhs_status_chk #(.NUM_PORTS(NUM_PORTS)) i_chk
(
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q),
    .per_port_mode(per_port_mode),
    .port_power_mask(port_power_mask),
    .port_set_power(port_set_power),
    .port_clr_power(port_clr_power),
    .overcurrent_in(overcurrent_in),
    .connect_change_flag(connect_change_flag),
    .port_power_q(port_power_q),
    .remote_wake_enable_q(remote_wake_enable_q),
    .resume_detected_q(resume_detected_q),
    .resuming_state_q(resuming_state_q)
);

/* File: test/tb_top.sv */
// Self-checking bench for the root hub global status register.
`timescale 1ns/1ns
module tb_top;
    import rhs_pkg::*;
    logic ref_clk = '0, sys_rst = '1, reg_wr = '0, reg_rd = '0, per_port_mode = '0, wk = '0;
    logic overcurrent_in = '0, suspend_req = '0, remote_wake_enable_q, resume_detected_q;
    logic resuming_state_q;
    logic [7:0] reg_addr = RHS_STATUS_OFFSET;
    logic [31:0] reg_wdata = '0, reg_rdata_q, d;
    logic [3:0] port_power_mask = '0, port_set_power = '0, port_clr_power = '0, m;
    logic [3:0] connect_change_flag = '0, port_power_q;
    int err_total = 0, cmp_count = 0, seed = 76824;
    rhs_global_status i_dut (.*);
    function automatic logic [31:0] rv(logic c, logic k, logic o);
        return {14'h0, c, 1'h0, k, 13'h0, o, 1'h0};
    endfunction
    function automatic logic nwk(logic o, logic [31:0] v);
        return v[31] ? 1'h0 : (v[15] ? 1'h1 : o);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    // Every access leaves one idle cycle, so strobes never toggle twice in a step.
    task automatic wr(input logic [31:0] v, input logic [7:0] a = RHS_STATUS_OFFSET);
        {reg_wr, reg_addr, reg_wdata} = {1'h1, a, v};
        tick(1);
        {reg_wr, reg_addr} = {1'h0, RHS_STATUS_OFFSET};
        tick(1);
    endtask
    task automatic rd(input logic [31:0] exp, input logic [7:0] a = RHS_STATUS_OFFSET);
        {reg_rd, reg_addr} = {1'h1, a};
        tick(1);
        {reg_rd, reg_addr} = {1'h0, RHS_STATUS_OFFSET};
        chk(reg_rdata_q, exp);
        tick(1);
    endtask
    task automatic watch(input logic exp);
        logic s = 1'h0;
        connect_change_flag = 4'h2;
        repeat (5)
        begin
            tick(1);
            s |= resume_detected_q & resuming_state_q;
        end
        connect_change_flag = 4'h0;
        chk(32'(s), 32'(exp));
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        #100000;
        err_total++;
        finish_test;
    end
    initial
    begin
        tick(10);
        sys_rst = 1'h0;
        rd(rv(0, 0, 0));
        repeat (24)
        begin
            d = $random(seed) & 32'h8000_8002;
            wr(d);
            wk = nwk(wk, d);
            rd(rv(0, wk, 0));
            chk(32'(remote_wake_enable_q), 32'(wk));
        end
        wr(32'h8000_8000, 8'h54);
        rd(32'h0, 8'h54);
        rd(rv(0, wk, 0));
        $display("wake test done");
        wr(32'h0001_0000);
        chk(32'(port_power_q), 32'hf);
        rd(rv(0, wk, 0));
        wr(32'h0000_0001);
        chk(32'(port_power_q), 32'h0);
        {per_port_mode, m} = {1'h1, 4'($random(seed))};
        port_power_mask = m;
        wr(32'h0001_0000);
        chk(32'(port_power_q), {28'h0, ~m});
        port_set_power = 4'hf;
        tick(1);
        port_set_power = 4'h0;
        wr(32'h0000_0001);
        chk(32'(port_power_q), 32'(m));
        $display("power test done");
        overcurrent_in = 1'h1;
        tick(2);
        rd(rv(1, wk, 1));
        wr(32'h0002_0002);
        rd(rv(0, wk, 1));
        overcurrent_in = 1'h0;
        tick(2);
        wr(32'h0000_0000);
        rd(rv(1, wk, 0));
        overcurrent_in = 1'h1;
        wr(32'h0002_0000);
        rd(rv(1, wk, 1));
        overcurrent_in = 1'h0;
        tick(2);
        $display("overcurrent test done");
        sys_rst = 1'h1;
        tick(2);
        sys_rst = 1'h0;
        wk = 1'h0;
        rd(32'h0);
        chk(32'(port_power_q), 32'h0);
        chk(32'(remote_wake_enable_q), 32'h0);
        $display("reset test done");
        wr(32'h8000_0000);
        suspend_req = 1'h1;
        tick(1);
        suspend_req = 1'h0;
        watch(1'h0);
        wr(32'h0000_8000);
        watch(1'h1);
        $display("resume test done");
        finish_test;
    end
endmodule
